// [mlrx_defs.svh]
// Offsets, field positions, reset values and timing counts of the multi-link receive sequencer.
`ifndef MLRX_DEFS_SVH
`define MLRX_DEFS_SVH

`define MLRX_CLK_MHZ          250
`define MLRX_ANA_RST_NS       200
`define MLRX_ANA_RST_CYC      ((`MLRX_ANA_RST_NS * `MLRX_CLK_MHZ + 999) / 1000)
`define MLRX_TX_DIG_NS        100
`define MLRX_TX_DIG_CYC       ((`MLRX_TX_DIG_NS * `MLRX_CLK_MHZ + 999) / 1000)
`define MLRX_RX_DIG_NS        400
`define MLRX_RX_DIG_CYC       ((`MLRX_RX_DIG_NS * `MLRX_CLK_MHZ + 999) / 1000)
`define MLRX_ILAS_TICKS       16

`define MLRX_SEQ_BASE         32'h000E_0000
`define MLRX_LINK0_CSR_BASE   32'h000D_0000
`define MLRX_LINK1_CSR_BASE   32'h000D_0400
`define MLRX_CSR_SPAN_MASK    32'hFFFF_FC00
`define MLRX_CSR_TESTMODE     32'h0000_00D0
`define MLRX_REG_CTRL         32'h0000_0000
`define MLRX_REG_STATUS       32'h0000_0004
`define MLRX_REG_ENABLE       32'h0000_0008
`define MLRX_REG_CLEAR        32'h0000_000C
`define MLRX_REG_STATE        32'h0000_0010

`define MLRX_CTRL_LINK_EN     0
`define MLRX_CTRL_RESET       32'h0000_0000
`define MLRX_EV_TX_READY      0
`define MLRX_EV_RX_READY      1
`define MLRX_EV_ALIGNED       2
`define MLRX_EV_DATA_ERR      3
`define MLRX_EV_LINK_IRQ      4
`define MLRX_EV_BITS          5

`endif

// [mlrx_pkg.sv]
// Types shared by the multi-link receive sequencer.
package mlrx_pkg;
  localparam int MLRX_LINKS = 2;
  localparam int MLRX_LANES = 2;
  localparam int MLRX_CH    = MLRX_LINKS * MLRX_LANES;
  localparam int MLRX_SPL   = 2 * MLRX_LANES;

  typedef struct packed {
    logic [MLRX_LANES-1:0][31:0] lane;
  } mlrx_lane_data_t;

  typedef struct packed {
    logic [MLRX_SPL-1:0][15:0] sample;
  } mlrx_samples_t;

  typedef struct packed {
    logic [MLRX_CH-1:0] analog;
    logic [MLRX_CH-1:0] digital;
  } mlrx_xcvr_rst_t;

  typedef enum logic [2:0] {
    MLRX_P_ANA   = 3'b000,
    MLRX_P_TXDIG = 3'b001,
    MLRX_P_RXDIG = 3'b010,
    MLRX_P_READY = 3'b011
  } mlrx_phy_st_t;

  typedef enum logic [1:0] {
    MLRX_S_PHY  = 2'b00,
    MLRX_S_CSR  = 2'b01,
    MLRX_S_LINK = 2'b10
  } mlrx_seq_st_t;

  typedef enum logic [2:0] {
    MLRX_C_IDLE = 3'b000,
    MLRX_C_CGS  = 3'b001,
    MLRX_C_ILAS = 3'b010,
    MLRX_C_WAIT = 3'b011,
    MLRX_C_DATA = 3'b100
  } mlrx_core_st_t;
endpackage

// [mlrx_sync.sv]
// Two flip-flop synchroniser for levels entering the system clock domain.
`timescale 1ns/100ps
module mlrx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // mlrx_sync

// [mlrx_seq.sv]
// Multi-link receive bring-up: transceiver resets, CSR and link resets, link cores, transport and checkers.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "mlrx_defs.svh"
module mlrx_seq
  import mlrx_pkg::*;
(
  input  wire logic                             clk_sys,
  input  wire logic                             srst,
  input  wire logic [31:0]                      addr,
  input  wire logic [31:0]                      wr_data,
  input  wire logic                             wr_stb,
  input  wire logic                             rd_stb,
  output logic      [31:0]                      rd_data,
  output logic                                  irq,
  input  wire logic                             link_clk,
  input  wire logic                             sysref,
  input  wire logic                             tx_pll_locked,
  input  wire logic [MLRX_CH-1:0]               rx_cdr_locked,
  input  wire logic [MLRX_LINKS-1:0]            cgs_lock,
  input  wire logic [MLRX_LINKS-1:0]            tx_link_irq,
  input  wire logic [MLRX_LINKS-1:0]            rx_link_irq,
  input  wire mlrx_lane_data_t [MLRX_LINKS-1:0] lane_data,
  output mlrx_xcvr_rst_t                        tx_xcvr_rst,
  output mlrx_xcvr_rst_t                        rx_xcvr_rst,
  output logic      [MLRX_LINKS-1:0]            tx_phy_ready,
  output logic      [MLRX_LINKS-1:0]            rx_phy_ready,
  output logic                                  csr_port_reset_n,
  output logic                                  link_reset_n,
  output logic      [MLRX_LINKS-1:0]            transport_accept_ready,
  output logic      [MLRX_LINKS-1:0]            sync_n,
  output logic                                  all_lanes_aligned,
  output logic      [MLRX_LINKS-1:0]            rx_sample_valid,
  output mlrx_samples_t [MLRX_LINKS-1:0]        samples,
  output logic      [MLRX_LINKS-1:0]            data_error,
  output logic                                  test_passed
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and link clock edge detection.
  logic                  link_clk_s;
  logic                  sysref_s;
  logic                  pll_s;
  logic [MLRX_CH-1:0]    cdr_s;
  logic [MLRX_LINKS-1:0] cgs_s;
  logic [MLRX_LINKS-1:0] tx_irq_s;
  logic [MLRX_LINKS-1:0] rx_irq_s;
  logic                  link_clk_d_reg;
  logic                  sysref_d_reg;
  logic                  link_tick;
  logic                  sysref_rise;

  mlrx_sync #(.W(3 + MLRX_CH + 3 * MLRX_LINKS)) u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .d       ({link_clk, sysref, tx_pll_locked, rx_cdr_locked, cgs_lock, tx_link_irq, rx_link_irq}),
    .q       ({link_clk_s, sysref_s, pll_s, cdr_s, cgs_s, tx_irq_s, rx_irq_s})
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_clk_d_reg <= 1'b0;
      sysref_d_reg   <= 1'b0;
    end else begin
      link_clk_d_reg <= link_clk_s;
      sysref_d_reg   <= sysref_s;
    end
  end

  assign link_tick   = link_clk_s & ~link_clk_d_reg;
  assign sysref_rise = sysref_s & ~sysref_d_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared transceiver reset controller covering the channels of all links.
  mlrx_phy_st_t phy_st_reg;
  logic [11:0]  phy_cnt_reg;
  logic         tx_ready_int;
  logic         rx_ready_int;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phy_st_reg          <= MLRX_P_ANA;
      phy_cnt_reg         <= '0;
      tx_xcvr_rst.analog  <= '1;
      tx_xcvr_rst.digital <= '1;
      rx_xcvr_rst.analog  <= '1;
      rx_xcvr_rst.digital <= '1;
    end else begin
      unique case (phy_st_reg)
        MLRX_P_ANA: begin
          phy_cnt_reg <= phy_cnt_reg + 12'h001;
          if (phy_cnt_reg == 12'(`MLRX_ANA_RST_CYC - 1)) begin
            tx_xcvr_rst.analog <= '0;
            rx_xcvr_rst.analog <= '0;
            phy_cnt_reg        <= '0;
            phy_st_reg         <= MLRX_P_TXDIG;
          end
        end
        MLRX_P_TXDIG: begin
          // The PLL must stay locked through the whole settle count.
          phy_cnt_reg <= pll_s ? phy_cnt_reg + 12'h001 : 12'h000;
          if (pll_s && phy_cnt_reg == 12'(`MLRX_TX_DIG_CYC - 1)) begin
            tx_xcvr_rst.digital <= '0;
            phy_cnt_reg         <= '0;
            phy_st_reg          <= MLRX_P_RXDIG;
          end
        end
        MLRX_P_RXDIG: begin
          phy_cnt_reg <= (&cdr_s) ? phy_cnt_reg + 12'h001 : 12'h000;
          rx_xcvr_rst.digital <= '1;
          if ((&cdr_s) && phy_cnt_reg == 12'(`MLRX_RX_DIG_CYC - 1)) begin
            rx_xcvr_rst.digital <= '0;
            phy_st_reg          <= MLRX_P_READY;
          end
        end
        MLRX_P_READY: begin
          // Losing recovery on any lane drops the receive side back into digital reset.
          if (!(&cdr_s)) begin
            rx_xcvr_rst.digital <= '1;
            phy_cnt_reg         <= '0;
            phy_st_reg          <= MLRX_P_RXDIG;
          end
        end
        default: begin
          phy_st_reg <= MLRX_P_ANA;
          phy_cnt_reg <= '0;
        end
      endcase
    end
  end

  assign tx_ready_int = (phy_st_reg == MLRX_P_RXDIG) || (phy_st_reg == MLRX_P_READY);
  assign rx_ready_int = (phy_st_reg == MLRX_P_READY) && (&cdr_s);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_phy_ready <= '0;
      rx_phy_ready <= '0;
    end else begin
      tx_phy_ready <= {MLRX_LINKS{tx_ready_int & pll_s}};
      rx_phy_ready <= {MLRX_LINKS{rx_ready_int}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System reset sequencer: CSR reset, then link reset once software enables the link.
  mlrx_seq_st_t seq_st_reg;
  logic [31:0]  ctrl_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seq_st_reg       <= MLRX_S_PHY;
      csr_port_reset_n <= 1'b0;
      link_reset_n     <= 1'b0;
    end else if (!rx_phy_ready[0]) begin
      seq_st_reg       <= MLRX_S_PHY;
      csr_port_reset_n <= 1'b0;
      link_reset_n     <= 1'b0;
    end else begin
      unique case (seq_st_reg)
        MLRX_S_PHY: begin
          csr_port_reset_n <= 1'b1;
          seq_st_reg       <= MLRX_S_CSR;
        end
        MLRX_S_CSR: begin
          // Holding here gives software time to load the test mode before the link runs.
          if (ctrl_reg[`MLRX_CTRL_LINK_EN]) begin
            link_reset_n <= 1'b1;
            seq_st_reg   <= MLRX_S_LINK;
          end
        end
        MLRX_S_LINK: begin
          if (!ctrl_reg[`MLRX_CTRL_LINK_EN]) begin
            link_reset_n <= 1'b0;
            seq_st_reg   <= MLRX_S_CSR;
          end
        end
        default: seq_st_reg <= MLRX_S_PHY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-link core, transport mapping and pattern checker.
  logic [MLRX_LINKS-1:0] dev_aligned;
  logic [MLRX_LINKS-1:0] link_err_ev;
  logic [MLRX_LINKS-1:0] irq_seen_reg;
  logic                  all_aligned_int;

  // Alignment stays masked while the link is held in reset.
  assign all_aligned_int = (&dev_aligned) & link_reset_n;

  genvar gi;
  generate
    for (gi = 0; gi < MLRX_LINKS; gi = gi + 1) begin : g_link
      mlrx_core_st_t core_st_reg;
      logic [7:0]    ilas_cnt_reg;
      logic          sysref_seen_reg;
      logic [15:0]   last_reg;
      logic          have_last_reg;
      mlrx_samples_t map;
      logic          mismatch;

      always_ff @(posedge clk_sys) begin
        if (srst || !link_reset_n) begin
          core_st_reg                <= MLRX_C_IDLE;
          ilas_cnt_reg               <= '0;
          sysref_seen_reg            <= 1'b0;
          sync_n[gi]                 <= 1'b0;
          dev_aligned[gi]            <= 1'b0;
          rx_sample_valid[gi]        <= 1'b0;
          transport_accept_ready[gi] <= 1'b0;
        end else begin
          if (sysref_rise) begin
            sysref_seen_reg <= 1'b1;
          end
          if (link_tick) begin
            transport_accept_ready[gi] <= 1'b1;
            unique case (core_st_reg)
              MLRX_C_IDLE: begin
                if (transport_accept_ready[gi]) begin
                  core_st_reg <= MLRX_C_CGS;
                end
              end
              MLRX_C_CGS: begin
                if (sysref_seen_reg && cgs_s[gi]) begin
                  sync_n[gi]  <= 1'b1;
                  core_st_reg <= MLRX_C_ILAS;
                end
              end
              MLRX_C_ILAS: begin
                ilas_cnt_reg <= ilas_cnt_reg + 8'h01;
                if (ilas_cnt_reg == 8'(`MLRX_ILAS_TICKS - 1)) begin
                  dev_aligned[gi] <= 1'b1;
                  core_st_reg     <= MLRX_C_WAIT;
                end
              end
              MLRX_C_WAIT: begin
                if (all_lanes_aligned) begin
                  rx_sample_valid[gi] <= 1'b1;
                  core_st_reg         <= MLRX_C_DATA;
                end
              end
              MLRX_C_DATA: begin
                // Losing code group lock forces a new synchronisation request.
                if (!cgs_s[gi]) begin
                  sync_n[gi]          <= 1'b0;
                  dev_aligned[gi]     <= 1'b0;
                  rx_sample_valid[gi] <= 1'b0;
                  sysref_seen_reg     <= 1'b0;
                  ilas_cnt_reg        <= '0;
                  core_st_reg         <= MLRX_C_CGS;
                end
              end
              default: core_st_reg <= MLRX_C_IDLE;
            endcase
          end
        end
      end

      // Each lane carries two 16-bit samples, most significant half-word first.
      always_comb begin
        map = '0;
        for (int l = 0; l < MLRX_LANES; l++) begin
          map.sample[2*l]     = lane_data[gi].lane[l][31:16];
          map.sample[2*l + 1] = lane_data[gi].lane[l][15:0];
        end
      end

      // The checker expects a ramp that steps by one per sample across words.
      always_comb begin
        mismatch = have_last_reg && (map.sample[0] != 16'(last_reg + 16'h0001));
        for (int s = 1; s < MLRX_SPL; s++) begin
          if (map.sample[s] != 16'(map.sample[s-1] + 16'h0001)) begin
            mismatch = 1'b1;
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (srst || !link_reset_n) begin
          samples[gi]    <= '0;
          last_reg       <= '0;
          have_last_reg  <= 1'b0;
          data_error[gi] <= 1'b0;
        end else if (link_tick && rx_sample_valid[gi]) begin
          samples[gi]   <= map;
          last_reg      <= map.sample[MLRX_SPL-1];
          have_last_reg <= 1'b1;
          if (mismatch) begin
            data_error[gi] <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          irq_seen_reg[gi] <= 1'b0;
        end else if (tx_irq_s[gi] || rx_irq_s[gi]) begin
          irq_seen_reg[gi] <= 1'b1;
        end
      end

      assign link_err_ev[gi] = tx_irq_s[gi] | rx_irq_s[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      all_lanes_aligned <= 1'b0;
      test_passed       <= 1'b0;
    end else begin
      all_lanes_aligned <= all_aligned_int;
      test_passed       <= (&rx_sample_valid) & ~(|data_error) & ~(|irq_seen_reg) & ~(|link_err_ev);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port, interrupt status and per-link test mode registers.
  logic [`MLRX_EV_BITS-1:0]   status_reg;
  logic [`MLRX_EV_BITS-1:0]   enable_reg;
  logic [`MLRX_EV_BITS-1:0]   events;
  logic [`MLRX_EV_BITS-1:0]   clr_mask;
  logic [MLRX_LINKS-1:0][31:0] testmode_reg;
  logic                        tx_ready_d_reg;
  logic                        rx_ready_d_reg;
  logic                        aligned_d_reg;
  logic                        err_d_reg;
  logic                        seq_win;
  logic [1:0]                  csr_hit;
  logic [31:0]                 rd_next;

  assign seq_win    = (addr & `MLRX_CSR_SPAN_MASK) == `MLRX_SEQ_BASE;
  assign csr_hit[0] = addr == (`MLRX_LINK0_CSR_BASE | `MLRX_CSR_TESTMODE);
  assign csr_hit[1] = addr == (`MLRX_LINK1_CSR_BASE | `MLRX_CSR_TESTMODE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_ready_d_reg <= 1'b0;
      rx_ready_d_reg <= 1'b0;
      aligned_d_reg  <= 1'b0;
      err_d_reg      <= 1'b0;
    end else begin
      tx_ready_d_reg <= tx_phy_ready[0];
      rx_ready_d_reg <= rx_phy_ready[0];
      aligned_d_reg  <= all_lanes_aligned;
      err_d_reg      <= |data_error;
    end
  end

  always_comb begin
    events = '0;
    events[`MLRX_EV_TX_READY] = tx_phy_ready[0] & ~tx_ready_d_reg;
    events[`MLRX_EV_RX_READY] = rx_phy_ready[0] & ~rx_ready_d_reg;
    events[`MLRX_EV_ALIGNED]  = all_lanes_aligned & ~aligned_d_reg;
    events[`MLRX_EV_DATA_ERR] = (|data_error) & ~err_d_reg;
    events[`MLRX_EV_LINK_IRQ] = |link_err_ev;
    clr_mask = '0;
    if (wr_stb && seq_win && addr[9:0] == `MLRX_REG_CLEAR) begin
      clr_mask = wr_data[`MLRX_EV_BITS-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_reg <= '0;
      enable_reg <= '0;
      ctrl_reg   <= `MLRX_CTRL_RESET;
      irq        <= 1'b0;
    end else begin
      // A new event outranks a clear of the same bit in the same cycle.
      status_reg <= (status_reg & ~clr_mask) | events;
      irq        <= |(status_reg & enable_reg);
      if (wr_stb && seq_win && addr[9:0] == `MLRX_REG_ENABLE) begin
        enable_reg <= wr_data[`MLRX_EV_BITS-1:0];
      end
      if (wr_stb && seq_win && addr[9:0] == `MLRX_REG_CTRL) begin
        ctrl_reg <= {31'h0000_0000, wr_data[`MLRX_CTRL_LINK_EN]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < MLRX_LINKS; k++) begin
      if (srst || !csr_port_reset_n) begin
        testmode_reg[k] <= '0;
      end else if (wr_stb && csr_hit[k]) begin
        testmode_reg[k] <= wr_data;
      end
    end
  end

  always_comb begin
    rd_next = '0;
    if (csr_hit[0] && csr_port_reset_n) begin
      rd_next = testmode_reg[0];
    end else if (csr_hit[1] && csr_port_reset_n) begin
      rd_next = testmode_reg[1];
    end else if (seq_win) begin
      unique case (addr[9:0])
        `MLRX_REG_CTRL:   rd_next = ctrl_reg;
        `MLRX_REG_STATUS: rd_next = {27'h000_0000, status_reg};
        `MLRX_REG_ENABLE: rd_next = {27'h000_0000, enable_reg};
        `MLRX_REG_STATE:  rd_next = {17'h0_0000, test_passed, all_lanes_aligned, data_error, rx_sample_valid,
                                     sync_n, link_reset_n, csr_port_reset_n, seq_st_reg, phy_st_reg};
        default:          rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_stb ? rd_next : 32'h0000_0000;
    end
  end
endmodule // mlrx_seq

// [mlrx_seq_asserts.sv]
// Port checks of the multi-link receive sequencer.
`timescale 1ns/100ps
module mlrx_seq_asserts
  import mlrx_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  srst,
  input wire mlrx_xcvr_rst_t        tx_xcvr_rst,
  input wire mlrx_xcvr_rst_t        rx_xcvr_rst,
  input wire logic [MLRX_LINKS-1:0] tx_phy_ready,
  input wire logic [MLRX_LINKS-1:0] rx_phy_ready,
  input wire logic                  csr_port_reset_n,
  input wire logic                  link_reset_n,
  input wire logic [MLRX_LINKS-1:0] transport_accept_ready,
  input wire logic [MLRX_LINKS-1:0] sync_n,
  input wire logic                  all_lanes_aligned,
  input wire logic [MLRX_LINKS-1:0] rx_sample_valid,
  input wire logic [MLRX_LINKS-1:0] data_error,
  input wire logic                  test_passed
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  ana_rst_a: assert property ($fell(srst) |-> &rx_xcvr_rst.analog ##[1:60] rx_xcvr_rst.analog == '0)
    else $error("analog reset sequence");
  tx_rdy_a: assert property ($rose(tx_phy_ready[0]) |-> tx_xcvr_rst == '0)
    else $error("tx ready under reset");
  rx_rdy_a: assert property ($rose(rx_phy_ready[0]) |-> rx_xcvr_rst == '0)
    else $error("rx ready under reset");
  csr_rel_a: assert property ($rose(csr_port_reset_n) |-> $past(rx_phy_ready[0]))
    else $error("csr released early");
  link_rel_a: assert property (link_reset_n |-> csr_port_reset_n)
    else $error("link released before csr");
  sync_rel_a: assert property ($rose(sync_n[0]) |-> transport_accept_ready[0] && link_reset_n)
    else $error("sync request cleared early");
  align_all_a: assert property ($rose(all_lanes_aligned) |-> &sync_n)
    else $error("aligned before every link");
  align_rst_a: assert property (!link_reset_n [*2] |-> !all_lanes_aligned)
    else $error("aligned in link reset");
  valid_on_a: assert property ($rose(rx_sample_valid[1]) |-> $past(all_lanes_aligned))
    else $error("valid before alignment");
  pass_ok_a: assert property (test_passed |-> &$past(rx_sample_valid) && $past(data_error) == '0)
    else $error("pass with error");
  rdy_copy_a: assert property (rx_phy_ready[1] == rx_phy_ready[0])
    else $error("rx ready copies differ");
  cover property ($rose(test_passed));
  cover property ($rose(&sync_n));
  cover property ($rose(|data_error));
endmodule // mlrx_seq_asserts

bind mlrx_seq mlrx_seq_asserts chk_u (.clk_sys(clk_sys), .srst(srst), .tx_xcvr_rst(tx_xcvr_rst),
  .rx_xcvr_rst(rx_xcvr_rst), .tx_phy_ready(tx_phy_ready), .rx_phy_ready(rx_phy_ready),
  .csr_port_reset_n(csr_port_reset_n), .link_reset_n(link_reset_n), .sync_n(sync_n),
  .transport_accept_ready(transport_accept_ready), .all_lanes_aligned(all_lanes_aligned),
  .rx_sample_valid(rx_sample_valid), .data_error(data_error), .test_passed(test_passed));

// [mlrx_conv_model.sv]
// Converter-side partner: device clock, SYSREF, locks and ramp lane data.
`timescale 1ns/100ps
module mlrx_conv_model
  import mlrx_pkg::*;
(
  input  wire logic                  lock,
  input  wire logic                  fire,
  input  wire logic                  bad,
  input  wire logic [MLRX_LINKS-1:0] sync_n,
  output logic                       link_clk,
  output logic                       sysref,
  output logic                       tx_pll_locked,
  output logic [MLRX_CH-1:0]         rx_cdr_locked,
  output logic [MLRX_LINKS-1:0]      cgs_lock,
  output mlrx_lane_data_t [MLRX_LINKS-1:0] lane_data
);
  logic [15:0] base;
  // The device clock runs free, as a converter sample clock does.
  initial link_clk = 1'b0;
  initial sysref = 1'b0;
  initial base = 16'h0000;
  initial lane_data = '0;
  always #62.5 link_clk = ~link_clk;
  assign tx_pll_locked = lock;
  assign rx_cdr_locked = {MLRX_CH{lock}};
  assign cgs_lock = {MLRX_LINKS{lock}};
  always @(posedge link_clk) sysref <= fire;
  // Lanes change mid-period so they are stable well past each sampling tick.
  always @(negedge link_clk) begin
    base <= base + 16'h0004;
    for (int k = 0; k < MLRX_LINKS; k++)
      for (int l = 0; l < MLRX_LANES; l++)
        lane_data[k].lane[l] <= sync_n[k] ? {base + 16'(2*l), base + 16'(2*l+1)} ^ {31'h0, bad} : 32'hBCBC_BCBC;
  end
endmodule // mlrx_conv_model

// [testbench.sv]
// Self-checking bench for the multi-link receive sequencer.
`timescale 1ns/100ps
`include "mlrx_defs.svh"
module testbench
  import mlrx_pkg::*;
;
  localparam logic [31:0] SB = `MLRX_SEQ_BASE;
  localparam logic [31:0] TM0 = `MLRX_LINK0_CSR_BASE + `MLRX_CSR_TESTMODE;
  localparam logic [31:0] TM1 = `MLRX_LINK1_CSR_BASE + `MLRX_CSR_TESTMODE;
  logic clk_sys, srst, wr_stb, rd_stb, irq, link_clk, sysref, tx_pll_locked, lock, fire, bad;
  logic csr_port_reset_n, link_reset_n, all_lanes_aligned, test_passed;
  logic [31:0] addr, wr_data, rd_data, v;
  logic [MLRX_CH-1:0] rx_cdr_locked;
  logic [MLRX_LINKS-1:0] cgs_lock, tx_link_irq, rx_link_irq, tx_phy_ready, rx_phy_ready;
  logic [MLRX_LINKS-1:0] transport_accept_ready, sync_n, rx_sample_valid, data_error;
  mlrx_lane_data_t [MLRX_LINKS-1:0] lane_data;
  mlrx_samples_t [MLRX_LINKS-1:0] samples;
  mlrx_xcvr_rst_t tx_xcvr_rst, rx_xcvr_rst;
  int mismatches, num_checks, cyc, n;

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  mlrx_seq dut_u (.clk_sys(clk_sys), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .link_clk(link_clk), .sysref(sysref),
    .tx_pll_locked(tx_pll_locked), .rx_cdr_locked(rx_cdr_locked), .cgs_lock(cgs_lock),
    .tx_link_irq(tx_link_irq), .rx_link_irq(rx_link_irq), .lane_data(lane_data),
    .tx_xcvr_rst(tx_xcvr_rst), .rx_xcvr_rst(rx_xcvr_rst), .tx_phy_ready(tx_phy_ready),
    .rx_phy_ready(rx_phy_ready), .csr_port_reset_n(csr_port_reset_n), .link_reset_n(link_reset_n),
    .transport_accept_ready(transport_accept_ready), .sync_n(sync_n), .all_lanes_aligned(all_lanes_aligned),
    .rx_sample_valid(rx_sample_valid), .samples(samples), .data_error(data_error), .test_passed(test_passed));
  mlrx_conv_model far_u (.lock(lock), .fire(fire), .bad(bad), .sync_n(sync_n), .link_clk(link_clk),
    .sysref(sysref), .tx_pll_locked(tx_pll_locked), .rx_cdr_locked(rx_cdr_locked), .cgs_lock(cgs_lock),
    .lane_data(lane_data));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Outputs are read once every register update has landed.
  task automatic step();
    @(posedge clk_sys) #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic t_idle();
    step();
    chk(32'(csr_port_reset_n), 0);
    chk(32'(link_reset_n), 0);
    wr(TM0, 32'h0000_00A5);
    rd(TM0);
    chk(v, 0);
    wr(SB + 32'h0000_0100, 32'hFFFF_FFFF);
    rd(SB + 32'h0000_0100);
    chk(v, 0);
    rd(SB + `MLRX_REG_STATUS);
    chk(v, 0);
    $display("idle done");
  endtask
  task automatic t_bringup();
    @(posedge clk_sys) lock <= 1'b1;
    for (n = 0; n < 2000 && rx_phy_ready !== 2'b11; n++) step();
    chk(32'(rx_phy_ready), 32'h3);
    chk(32'(tx_phy_ready), 32'h3);
    chk({24'h0, rx_xcvr_rst}, 0);
    for (n = 0; n < 50 && !csr_port_reset_n; n++) step();
    chk(32'(link_reset_n), 0);
    wr(TM1, 32'h0000_0011);
    wr(TM0, 32'h0000_0022);
    rd(TM1);
    chk(v, 32'h0000_0011);
    rd(TM0);
    chk(v, 32'h0000_0022);
    wr(SB + `MLRX_REG_ENABLE, 32'h0000_001F);
    wr(SB + `MLRX_REG_CTRL, 32'h0000_0001);
    for (n = 0; n < 200 && transport_accept_ready !== 2'b11; n++) step();
    chk(32'(link_reset_n), 1);
    chk(32'(transport_accept_ready), 32'h3);
    repeat (100) step();
    chk(32'(sync_n), 0);
    @(posedge clk_sys) fire <= 1'b1;
    repeat (40) @(posedge clk_sys);
    fire <= 1'b0;
    for (n = 0; n < 400 && sync_n !== 2'b11; n++) step();
    chk(32'(sync_n), 32'h3);
    for (n = 0; n < 900 && !all_lanes_aligned; n++) step();
    chk(32'(all_lanes_aligned), 1);
    for (n = 0; n < 200 && rx_sample_valid !== 2'b11; n++) step();
    chk(32'(rx_sample_valid), 32'h3);
    repeat (40) step();
    chk(32'(samples[0].sample[1]), 32'(samples[0].sample[0] + 16'h1));
    chk(32'(samples[1].sample[2]), 32'(samples[1].sample[0] + 16'h2));
    chk(32'(test_passed), 1);
    rd(SB + `MLRX_REG_STATUS);
    chk(v & 32'h0000_0007, 32'h0000_0007);
    rd(SB + `MLRX_REG_STATE);
    chk(v, 32'h0000_67F3);
    chk(32'(irq), 1);
    $display("bringup done");
  endtask
  task automatic t_errors();
    wr(SB + `MLRX_REG_ENABLE, 0);
    wr(SB + `MLRX_REG_CLEAR, 32'h0000_001F);
    rd(SB + `MLRX_REG_STATUS);
    chk(v, 0);
    @(posedge clk_sys) bad <= 1'b1;
    for (n = 0; n < 200 && data_error !== 2'b11; n++) step();
    step();
    chk(32'(data_error), 32'h3);
    chk(32'(test_passed), 0);
    chk(32'(irq), 0);
    wr(SB + `MLRX_REG_ENABLE, 32'h0000_0008);
    repeat (3) step();
    chk(32'(irq), 1);
    wr(SB + `MLRX_REG_CLEAR, 32'h0000_0008);
    repeat (3) step();
    chk(32'(irq), 0);
    @(posedge clk_sys) tx_link_irq <= 2'b10;
    rx_link_irq <= 2'b01;
    repeat (6) step();
    rd(SB + `MLRX_REG_STATUS);
    chk(v & 32'h0000_0010, 32'h0000_0010);
    $display("errors done");
  endtask
  task automatic t_lockloss();
    @(posedge clk_sys) lock <= 1'b0;
    for (n = 0; n < 200 && rx_phy_ready !== 2'b00; n++) step();
    chk(32'(rx_phy_ready), 0);
    @(posedge clk_sys) srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    step();
    chk(32'(csr_port_reset_n), 0);
    $display("lockloss done");
  endtask
  initial begin
    {srst, addr, wr_data, wr_stb, rd_stb, lock, fire, bad, tx_link_irq, rx_link_irq} = '0;
    srst = 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_idle();
    t_bringup();
    t_errors();
    t_lockloss();
    conclude();
  end
endmodule // testbench
